// [hdl/ext_timer_ctrl_status.sv]
// The strobed register port was decided locally.
`timescale 1ns/1ps
// Behaviour
// - Capture enable gates capture flags onto interrupt
// - Compare enable gates compare flags onto interrupt
// - Overflow enable gates overflow flag onto interrupt
// - Force bits copy level bit to pin
// - Compare 2 match drives level 2 out
// - Compare 1 match drives level 1 out
// - Pulse modes drive pin 1 from level 2
// - Capture 1 edge chosen by edge bit 1
// - Capture 2 edge chosen by edge bit 2
// - Dedication bit hands pin to timer
// - One-pulse mode: capture edge starts pulse
// - PWM: compare 1 length, compare 2 period
// - Clock select: div4, div2, div8, external
// - External edge bit picks counting edge
// - Capture flag 1 set, cleared by sequence
// - Compare flag 1 set, cleared by sequence
// - Overflow flag set on wrap, sequence clear
// - Alternate counter access never clears overflow
// - Capture flag 2 set, cleared by sequence
// - Compare flag 2 set, cleared by sequence
// - Status bits 2..0 read zero
// - Route bits steer interrupt lines; 7..4 zero
// - Counter low byte writes reset counter
// - Capture copies counter into capture registers
module ext_timer_ctrl_status (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic capture_pin_ch1,
  input wire logic capture_pin_ch2,
  input wire logic external_timer_clock_pin,
  output logic compare_pin_ch1,
  output logic compare_pin_ch2,
  output logic compare_pin_dedicate_ch1,
  output logic compare_pin_dedicate_ch2,
  output logic timer_irq,
  output ext_timer_pkg::irq_lines_s irq_to_timer,
  output ext_timer_pkg::irq_lines_s irq_to_external
);
  logic [7:0] ctrl1_ff;
  logic [7:0] ctrl2_ff;
  logic [3:0] route_ff;
  logic [15:0] cnt_ff;
  logic [15:0] cmp1_ff;
  logic [15:0] cmp2_ff;
  logic [15:0] cap1_ff;
  logic [15:0] cap2_ff;
  ext_timer_pkg::flags_s flags_ff;
  ext_timer_pkg::flags_s armed_ff;
  logic [2:0] pre_ff;
  logic cap1_d_ff;
  logic cap2_d_ff;
  logic ext_d_ff;
  logic pulse_on_ff;
  logic tick;
  logic cap1_evt;
  logic cap2_evt;
  logic match1;
  logic match2;
  logic ovf_evt;
  logic cnt_wr;
  logic pulse_mode;
  logic [2:0] pre_mask;
  ext_timer_pkg::flags_s clr;
  ext_timer_pkg::irq_lines_s lines;

  // Prescaler and external clock edge selection
  always_comb begin
    unique case (ctrl2_ff[ext_timer_pkg::C2_CLK_HI:ext_timer_pkg::C2_CLK_LO])
      ext_timer_pkg::CLK_DIV2: pre_mask = ext_timer_pkg::PRE_MASK2;
      ext_timer_pkg::CLK_DIV8: pre_mask = ext_timer_pkg::PRE_MASK8;
      default: pre_mask = ext_timer_pkg::PRE_MASK4;
    endcase
    if (ctrl2_ff[ext_timer_pkg::C2_CLK_HI:ext_timer_pkg::C2_CLK_LO] == ext_timer_pkg::CLK_EXT)
    begin
      tick = ctrl2_ff[ext_timer_pkg::C2_EXT_EDGE] ? (external_timer_clock_pin & ~ext_d_ff)
                                                  : (~external_timer_clock_pin & ext_d_ff);
    end else begin
      tick = ((pre_ff & pre_mask) == pre_mask);
    end
  end

  // Capture edges, matches and overflow
  assign cap1_evt = ctrl1_ff[ext_timer_pkg::C1_EDGE1] ? (capture_pin_ch1 & ~cap1_d_ff)
                                                      : (~capture_pin_ch1 & cap1_d_ff);
  assign cap2_evt = ctrl2_ff[ext_timer_pkg::C2_EDGE2] ? (capture_pin_ch2 & ~cap2_d_ff)
                                                      : (~capture_pin_ch2 & cap2_d_ff);
  assign cnt_wr = wr & ((addr == ext_timer_pkg::ADDR_CNT_LO) |
                        (addr == ext_timer_pkg::ADDR_ACNT_LO));
  assign match1 = (cnt_ff == cmp1_ff);
  assign match2 = (cnt_ff == cmp2_ff);
  assign ovf_evt = tick & ~cnt_wr & (cnt_ff == ext_timer_pkg::CNT_MAX);
  assign pulse_mode = ctrl2_ff[ext_timer_pkg::C2_OPM] | ctrl2_ff[ext_timer_pkg::C2_PWM];

  // Clear requests: armed by a status read, fired by access to the low byte
  always_comb begin
    clr.cap1 = armed_ff.cap1 & (rd | wr) & (addr == ext_timer_pkg::ADDR_CAP1_LO);
    clr.cmp1 = armed_ff.cmp1 & (rd | wr) & (addr == ext_timer_pkg::ADDR_CMP1_LO);
    clr.ovf = armed_ff.ovf & (rd | wr) & (addr == ext_timer_pkg::ADDR_CNT_LO);
    clr.cap2 = armed_ff.cap2 & (rd | wr) & (addr == ext_timer_pkg::ADDR_CAP2_LO);
    clr.cmp2 = armed_ff.cmp2 & (rd | wr) & (addr == ext_timer_pkg::ADDR_CMP2_LO);
  end

  // Input sampling for edge detection
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cap1_d_ff <= 1'b0;
      cap2_d_ff <= 1'b0;
      ext_d_ff <= 1'b0;
    end else begin
      cap1_d_ff <= capture_pin_ch1;
      cap2_d_ff <= capture_pin_ch2;
      ext_d_ff <= external_timer_clock_pin;
    end
  end

  // Prescaler runs free; reloaded with the counter on a counter write
  always_ff @(posedge ref_clk) begin
    if (!rstn || cnt_wr) begin
      pre_ff <= 3'h0;
    end else begin
      pre_ff <= pre_ff + 3'h1;
    end
  end

  // Free-running counter; PWM restarts the period on compare 2
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_ff <= ext_timer_pkg::CNT_RST;
    end else if (cnt_wr) begin
      cnt_ff <= ext_timer_pkg::CNT_RST;
    end else if (tick) begin
      if (ctrl2_ff[ext_timer_pkg::C2_PWM] && match2) begin
        cnt_ff <= ext_timer_pkg::CNT_CLEARED;
      end else if (ctrl2_ff[ext_timer_pkg::C2_OPM] && cap1_evt) begin
        cnt_ff <= ext_timer_pkg::CNT_CLEARED;
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end else if (ctrl2_ff[ext_timer_pkg::C2_OPM] && cap1_evt) begin
      cnt_ff <= ext_timer_pkg::CNT_CLEARED;
    end
  end

  // Capture registers latch the counter on the active edge
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cap1_ff <= 16'h0000;
      cap2_ff <= 16'h0000;
    end else begin
      if (cap1_evt) begin
        cap1_ff <= cnt_ff;
      end
      if (cap2_evt) begin
        cap2_ff <= cnt_ff;
      end
    end
  end

  // Software registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl1_ff <= ext_timer_pkg::CTRL_RST;
      ctrl2_ff <= ext_timer_pkg::CTRL_RST;
      route_ff <= 4'h0;
      cmp1_ff <= ext_timer_pkg::CMP_RST;
      cmp2_ff <= ext_timer_pkg::CMP_RST;
    end else if (wr) begin
      unique case (addr)
        ext_timer_pkg::ADDR_CTRL1: ctrl1_ff <= wdata;
        ext_timer_pkg::ADDR_CTRL2: ctrl2_ff <= wdata;
        ext_timer_pkg::ADDR_ROUTE: route_ff <= wdata[ext_timer_pkg::ROUTE_W-1:0];
        ext_timer_pkg::ADDR_CMP1_HI: cmp1_ff[15:8] <= wdata;
        ext_timer_pkg::ADDR_CMP1_LO: cmp1_ff[7:0] <= wdata;
        ext_timer_pkg::ADDR_CMP2_HI: cmp2_ff[15:8] <= wdata;
        ext_timer_pkg::ADDR_CMP2_LO: cmp2_ff[7:0] <= wdata;
        default: ;
      endcase
    end
  end

  // Flags: a set in the clearing cycle wins; status read arms clearing
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flags_ff <= '0;
      armed_ff <= '0;
    end else begin
      flags_ff.cap1 <= cap1_evt | (flags_ff.cap1 & ~clr.cap1);
      flags_ff.cmp1 <= (tick & match1) | (flags_ff.cmp1 & ~clr.cmp1);
      flags_ff.ovf <= ovf_evt | (flags_ff.ovf & ~clr.ovf);
      flags_ff.cap2 <= cap2_evt | (flags_ff.cap2 & ~clr.cap2);
      flags_ff.cmp2 <= (tick & match2) | (flags_ff.cmp2 & ~clr.cmp2);
      if (rd && addr == ext_timer_pkg::ADDR_FLAGS) begin
        armed_ff <= flags_ff;
      end else begin
        armed_ff <= armed_ff & ~clr;
      end
    end
  end

  // Compare outputs; one-pulse ends at compare 1, PWM returns at period
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      compare_pin_ch1 <= 1'b0;
      compare_pin_ch2 <= 1'b0;
      pulse_on_ff <= 1'b0;
    end else begin
      if (ctrl2_ff[ext_timer_pkg::C2_OPM] && cap1_evt) begin
        compare_pin_ch1 <= ctrl1_ff[ext_timer_pkg::C1_LVL2];
        pulse_on_ff <= 1'b1;
      end else if (wr && addr == ext_timer_pkg::ADDR_CTRL1 && wdata[ext_timer_pkg::C1_FORCE1])
      begin
        compare_pin_ch1 <= pulse_mode ? wdata[ext_timer_pkg::C1_LVL2]
                                      : wdata[ext_timer_pkg::C1_LVL1];
      end else if (tick && ctrl2_ff[ext_timer_pkg::C2_PWM]) begin
        if (match1) begin
          compare_pin_ch1 <= ctrl1_ff[ext_timer_pkg::C1_LVL2];
        end else if (match2) begin
          compare_pin_ch1 <= ~ctrl1_ff[ext_timer_pkg::C1_LVL2];
        end
      end else if (tick && match1) begin
        if (ctrl2_ff[ext_timer_pkg::C2_OPM]) begin
          if (pulse_on_ff) begin
            compare_pin_ch1 <= ~ctrl1_ff[ext_timer_pkg::C1_LVL2];
            pulse_on_ff <= 1'b0;
          end
        end else if (ctrl2_ff[ext_timer_pkg::C2_DED1]) begin
          compare_pin_ch1 <= ctrl1_ff[ext_timer_pkg::C1_LVL1];
        end
      end
      if (wr && addr == ext_timer_pkg::ADDR_CTRL1 && wdata[ext_timer_pkg::C1_FORCE2]) begin
        compare_pin_ch2 <= wdata[ext_timer_pkg::C1_LVL2];
      end else if (tick && match2 && ctrl2_ff[ext_timer_pkg::C2_DED2]) begin
        compare_pin_ch2 <= ctrl1_ff[ext_timer_pkg::C1_LVL2];
      end
    end
  end

  // Interrupt lines and their routing
  always_comb begin
    lines.cap = ctrl1_ff[ext_timer_pkg::C1_CAP_IE] & (flags_ff.cap1 | flags_ff.cap2);
    lines.cmp = ctrl1_ff[ext_timer_pkg::C1_CMP_IE] & (flags_ff.cmp1 | flags_ff.cmp2);
    lines.ovf = ctrl1_ff[ext_timer_pkg::C1_OVF_IE] & flags_ff.ovf;
    lines.glob = lines.cap | lines.cmp | lines.ovf;
  end

  // Registered interrupt and pin-dedication outputs
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      timer_irq <= 1'b0;
      irq_to_timer <= '0;
      irq_to_external <= '0;
      compare_pin_dedicate_ch1 <= 1'b0;
      compare_pin_dedicate_ch2 <= 1'b0;
    end else begin
      timer_irq <= lines.glob;
      irq_to_timer <= lines & route_ff;
      irq_to_external <= lines & ~route_ff;
      compare_pin_dedicate_ch1 <= ctrl2_ff[ext_timer_pkg::C2_DED1] | pulse_mode;
      compare_pin_dedicate_ch2 <= ctrl2_ff[ext_timer_pkg::C2_DED2];
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        ext_timer_pkg::ADDR_CAP1_HI: rdata <= cap1_ff[15:8];
        ext_timer_pkg::ADDR_CAP1_LO: rdata <= cap1_ff[7:0];
        ext_timer_pkg::ADDR_CAP2_HI: rdata <= cap2_ff[15:8];
        ext_timer_pkg::ADDR_CAP2_LO: rdata <= cap2_ff[7:0];
        ext_timer_pkg::ADDR_CNT_HI, ext_timer_pkg::ADDR_ACNT_HI: rdata <= cnt_ff[15:8];
        ext_timer_pkg::ADDR_CNT_LO, ext_timer_pkg::ADDR_ACNT_LO: rdata <= cnt_ff[7:0];
        ext_timer_pkg::ADDR_CMP1_HI: rdata <= cmp1_ff[15:8];
        ext_timer_pkg::ADDR_CMP1_LO: rdata <= cmp1_ff[7:0];
        ext_timer_pkg::ADDR_CMP2_HI: rdata <= cmp2_ff[15:8];
        ext_timer_pkg::ADDR_CMP2_LO: rdata <= cmp2_ff[7:0];
        ext_timer_pkg::ADDR_CTRL1: rdata <= ctrl1_ff;
        ext_timer_pkg::ADDR_CTRL2: rdata <= ctrl2_ff;
        ext_timer_pkg::ADDR_FLAGS: rdata <= {flags_ff, 3'h0};
        ext_timer_pkg::ADDR_ROUTE: rdata <= {4'h0, route_ff};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Checks
  chk_cap1_capture: assert property (@(posedge ref_clk) disable iff (!rstn)
    cap1_evt |=> (cap1_ff == $past(cnt_ff) && flags_ff.cap1))
    else $error("capture 1 not taken");
  chk_cap_irq: assert property (@(posedge ref_clk) disable iff (!rstn)
    (flags_ff.cap2 && ctrl1_ff[7]) |=> timer_irq)
    else $error("capture irq missing");
  chk_cmp_irq_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ctrl1_ff[7:5] == 3'h0) |=> !timer_irq)
    else $error("irq without enable");
  chk_ovf_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    ovf_evt |=> (flags_ff.ovf && cnt_ff == 16'h0000))
    else $error("overflow not flagged");
  chk_alt_no_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    (flags_ff.ovf && (rd || wr) && addr == ext_timer_pkg::ADDR_ACNT_LO) |=> flags_ff.ovf)
    else $error("alternate access cleared overflow");
  chk_cnt_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
    cnt_wr |=> cnt_ff == ext_timer_pkg::CNT_RST)
    else $error("counter not reset by write");
  chk_flags_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rd && addr == ext_timer_pkg::ADDR_FLAGS) |=> rdata[2:0] == 3'h0)
    else $error("reserved status bits set");
  chk_cmp2_pin: assert property (@(posedge ref_clk) disable iff (!rstn)
    (tick && match2 && ctrl2_ff[6] && !wr) |=> compare_pin_ch2 == $past(ctrl1_ff[2]))
    else $error("compare 2 pin wrong");
  chk_cnt_step: assert property (@(posedge ref_clk) disable iff (!rstn)
    (tick && !cnt_wr && !pulse_mode) |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("counter did not step");
endmodule

// [hdl/ext_timer_pkg.sv]
package ext_timer_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] ADDR_CAP1_HI = 8'hF0;
  localparam logic [7:0] ADDR_CAP1_LO = 8'hF1;
  localparam logic [7:0] ADDR_CAP2_HI = 8'hF2;
  localparam logic [7:0] ADDR_CAP2_LO = 8'hF3;
  localparam logic [7:0] ADDR_CNT_HI = 8'hF4;
  localparam logic [7:0] ADDR_CNT_LO = 8'hF5;
  localparam logic [7:0] ADDR_ACNT_HI = 8'hF6;
  localparam logic [7:0] ADDR_ACNT_LO = 8'hF7;
  localparam logic [7:0] ADDR_CMP1_HI = 8'hF8;
  localparam logic [7:0] ADDR_CMP1_LO = 8'hF9;
  localparam logic [7:0] ADDR_CMP2_HI = 8'hFA;
  localparam logic [7:0] ADDR_CMP2_LO = 8'hFB;
  localparam logic [7:0] ADDR_CTRL1 = 8'hFC;
  localparam logic [7:0] ADDR_CTRL2 = 8'hFD;
  localparam logic [7:0] ADDR_FLAGS = 8'hFE;
  localparam logic [7:0] ADDR_ROUTE = 8'hFF;

  // Reset values, cleared counter value and counter maximum
  localparam logic [15:0] CNT_RST = 16'hFFFC;
  localparam logic [15:0] CMP_RST = 16'h8000;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CNT_CLEARED = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  // First control register fields
  localparam int C1_CAP_IE = 7;
  localparam int C1_CMP_IE = 6;
  localparam int C1_OVF_IE = 5;
  localparam int C1_FORCE2 = 4;
  localparam int C1_FORCE1 = 3;
  localparam int C1_LVL2 = 2;
  localparam int C1_EDGE1 = 1;
  localparam int C1_LVL1 = 0;
  // Second control register fields
  localparam int C2_DED1 = 7;
  localparam int C2_DED2 = 6;
  localparam int C2_OPM = 5;
  localparam int C2_PWM = 4;
  localparam int C2_CLK_HI = 3;
  localparam int C2_CLK_LO = 2;
  localparam int C2_EDGE2 = 1;
  localparam int C2_EXT_EDGE = 0;
  // Route register width (bits 7:4 read zero)
  localparam int ROUTE_W = 4;

  // Clock select codes and prescaler
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam logic [2:0] PRE_MASK2 = 3'h1;
  localparam logic [2:0] PRE_MASK4 = 3'h3;
  localparam logic [2:0] PRE_MASK8 = 3'h7;

  // Status flags
  typedef struct packed {
    logic cap1;
    logic cmp1;
    logic ovf;
    logic cap2;
    logic cmp2;
  } flags_s;

  // Interrupt lines by routing
  typedef struct packed {
    logic ovf;
    logic cmp;
    logic cap;
    logic glob;
  } irq_lines_s;
endpackage

// [bench/timer_pins_model.sv]
`timescale 1ns/1ps
// Far side of the timer pins: capture inputs and external clock
module timer_pins_model (
  input wire logic ref_clk,
  output logic capture_pin_ch1,
  output logic capture_pin_ch2,
  output logic external_timer_clock_pin
);
  // Idle levels; the external clock stands still between bursts
  initial begin
    capture_pin_ch1 = 1'b1;
    capture_pin_ch2 = 1'b0;
    external_timer_clock_pin = 1'b0;
  end
  // New capture level, held long enough for the pin sampler
  task automatic set_cap(input int ch, input logic lvl);
    @(posedge ref_clk);
    if (ch == 1) capture_pin_ch1 <= lvl;
    else capture_pin_ch2 <= lvl;
    repeat (4) @(posedge ref_clk);
  endtask
  // Pulses three cycles per phase so no edge is lost in sampling
  task automatic ext_burst(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      external_timer_clock_pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
      external_timer_clock_pin <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
  endtask
endmodule

// [bench/ext_timer_ctrl_status_bench.sv]
`timescale 1ns/1ps
module ext_timer_ctrl_status_bench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic cap1, cap2, ext_clk;
  logic pin1, pin2, ded1, ded2, timer_irq;
  ext_timer_pkg::irq_lines_s irq_t, irq_e;
  int fail_count = 0;
  int total_checks = 0;
  logic [7:0] d;
  int hi;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} row_s;
  // Write then read back; read-only and unmapped places keep zero
  row_s rows[9] = '{'{8'hF8, 8'h12, 8'h12}, '{8'hF9, 8'h34, 8'h34},
    '{8'hFA, 8'h56, 8'h56}, '{8'hFB, 8'h78, 8'h78}, '{8'hFF, 8'hFF, 8'h0F},
    '{8'hFF, 8'h00, 8'h00}, '{8'hF0, 8'hAA, 8'h00}, '{8'hF2, 8'hAA, 8'h00},
    '{8'h00, 8'hAA, 8'h00}};
  int divs[3] = '{4, 2, 8};

  always #2 ref_clk = ~ref_clk;

  ext_timer_ctrl_status ext_timer_ctrl_status_i (.ref_clk(ref_clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .capture_pin_ch1(cap1), .capture_pin_ch2(cap2), .external_timer_clock_pin(ext_clk),
    .compare_pin_ch1(pin1), .compare_pin_ch2(pin2), .compare_pin_dedicate_ch1(ded1),
    .compare_pin_dedicate_ch2(ded2), .timer_irq(timer_irq), .irq_to_timer(irq_t),
    .irq_to_external(irq_e));
  timer_pins_model timer_pins_model_i (.ref_clk(ref_clk), .capture_pin_ch1(cap1),
    .capture_pin_ch2(cap2), .external_timer_clock_pin(ext_clk));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle strobes, launched just after a rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] w);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= w;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, well beyond the run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    // Reset values, before the counter can wrap
    rd_reg(8'hFE, d); check(d, 8'h00);
    rd_reg(8'hF8, d); check(d, 8'h80);
    rd_reg(8'hFC, d); check(d, 8'h00);
    rd_reg(8'hFF, d); check(d, 8'h00);
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].w);
      rd_reg(rows[i].a, d);
      check(d, rows[i].e);
    end
    $display("test registers done");
    // Overflow from reset value: gating, routing, clearing
    wr_reg(8'hFF, 8'h0F);
    wr_reg(8'hFC, 8'h20);
    idle(3);
    check(timer_irq, 8'h01);
    check(irq_t, 8'h09);
    wr_reg(8'hFF, 8'h00);
    idle(3);
    check({irq_e.glob, irq_t.glob}, 8'h02);
    wr_reg(8'hFC, 8'h00);
    idle(3);
    check(timer_irq, 8'h00);
    rd_reg(8'hFE, d); check(d & 8'h27, 8'h20);
    rd_reg(8'hF7, d);
    rd_reg(8'hFE, d); check(d & 8'h20, 8'h20);
    rd_reg(8'hF5, d);
    rd_reg(8'hFE, d); check(d & 8'h20, 8'h00);
    $display("test overflow done");
    // Capture 1 on falling edge, value, clear, rising ignored
    wr_reg(8'hFC, 8'h80);
    wr_reg(8'hF5, 8'h00);
    timer_pins_model_i.set_cap(1, 1'b0);
    check(timer_irq, 8'h01);
    rd_reg(8'hFE, d); check(d & 8'h87, 8'h80);
    rd_reg(8'hF0, d); check(d, 8'hFF);
    rd_reg(8'hF1, d); check(d & 8'hFC, 8'hFC);
    rd_reg(8'hFE, d); check(d & 8'h80, 8'h00);
    idle(2);
    check(timer_irq, 8'h00);
    timer_pins_model_i.set_cap(1, 1'b1);
    rd_reg(8'hFE, d); check(d & 8'h80, 8'h00);
    // Capture 2 on rising edge
    wr_reg(8'hFD, 8'h02);
    timer_pins_model_i.set_cap(2, 1'b1);
    rd_reg(8'hFE, d); check(d & 8'h10, 8'h10);
    rd_reg(8'hF3, d);
    rd_reg(8'hFE, d); check(d & 8'h10, 8'h00);
    $display("test capture done");
    // Compare 2 match drives level 2 onto a dedicated pin
    wr_reg(8'hFA, 8'hFF);
    wr_reg(8'hFB, 8'hFE);
    wr_reg(8'hFD, 8'h40);
    wr_reg(8'hFC, 8'h44);
    wr_reg(8'hF5, 8'h00);
    idle(20);
    check({ded2, pin2}, 8'h03);
    check(timer_irq, 8'h01);
    rd_reg(8'hFE, d); check(d & 8'h08, 8'h08);
    rd_reg(8'hFB, d);
    rd_reg(8'hFE, d); check(d & 8'h08, 8'h00);
    wr_reg(8'hFC, 8'h10);
    idle(2);
    check(pin2, 8'h00);
    // Compare 1: force high, then match drives level 1 low
    wr_reg(8'hF8, 8'hFF);
    wr_reg(8'hF9, 8'hFE);
    wr_reg(8'hFD, 8'hC0);
    wr_reg(8'hFC, 8'h09);
    idle(2);
    check(pin1, 8'h01);
    wr_reg(8'hFC, 8'h00);
    wr_reg(8'hF5, 8'h00);
    idle(20);
    check(pin1, 8'h00);
    rd_reg(8'hFE, d); check(d & 8'h40, 8'h40);
    rd_reg(8'hF9, d);
    rd_reg(8'hFE, d); check(d & 8'h40, 8'h00);
    wr_reg(8'hFD, 8'h00);
    idle(2);
    check(ded1, 8'h00);
    $display("test compare done");
    // Prescaled rates: low byte after 96 cycles from FFFC
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'hFD, 8'(i << 2));
      wr_reg(8'hF5, 8'h00);
      idle(96);
      rd_reg(8'hF5, d);
      hi = int'(d) - (96 / divs[i] - 4);
      check(8'(hi >= -2 && hi <= 2), 8'h01);
    end
    // External clock on either edge: ten edges from FFFC
    for (int e = 0; e < 2; e++) begin
      wr_reg(8'hFD, 8'h0C | 8'(e));
      wr_reg(8'hF5, 8'h00);
      timer_pins_model_i.ext_burst(10);
      idle(4);
      rd_reg(8'hF5, d); check(d, 8'h06);
    end
    $display("test clock done");
    // PWM: high from compare 1 to compare 2, two thirds duty
    wr_reg(8'hF8, 8'h00);
    wr_reg(8'hF9, 8'h02);
    wr_reg(8'hFA, 8'h00);
    wr_reg(8'hFB, 8'h08);
    wr_reg(8'hFD, 8'h90);
    wr_reg(8'hFC, 8'h04);
    wr_reg(8'hF5, 8'h00);
    idle(40);
    hi = 0;
    repeat (64) begin
      @(posedge ref_clk);
      #1;
      hi += int'(pin1 === 1'b1);
    end
    check(8'(hi > 32 && hi < 64), 8'h01);
    // One pulse: falling capture edge starts 16-tick pulse
    wr_reg(8'hF9, 8'h10);
    wr_reg(8'hFD, 8'hA0);
    timer_pins_model_i.set_cap(1, 1'b0);
    check({ded1, pin1}, 8'h03);
    idle(80);
    check(pin1, 8'h00);
    $display("test pulse modes done");
    // Reset in mid-run: outputs drop, counter and flags restart
    @(posedge ref_clk);
    rstn <= 1'b0;
    idle(2);
    check({timer_irq, pin1, pin2, ded1, ded2}, 8'h00);
    @(posedge ref_clk);
    rstn <= 1'b1;
    rd_reg(8'hF5, d); check(d, 8'hFC);
    rd_reg(8'hFE, d); check(d, 8'h00);
    $display("test reset done");
    final_report();
  end
endmodule
